// ### epr_regs.svh
`ifndef EPR_REGS_SVH
`define EPR_REGS_SVH
// ****************************************
// timing
// ****************************************
// clock period in ns, timer tick nominally 100 ms
`define EPR_CLK_NS 20
`define EPR_TICK_MS 100
`define EPR_TICK_CYC ((`EPR_TICK_MS * 1000000) / `EPR_CLK_NS)
// switch bank field positions
`define EPR_SW_ST_A 0
`define EPR_SW_RT_A 1
`define EPR_SW_RT_B 2
`define EPR_SW_RT_C 3
`define EPR_SW_RT_D 4
`define EPR_SW_ST_B 5
`define EPR_SW_RST 6'h00
`endif

// ### epr_pkg.sv
package epr_pkg;
	typedef enum logic {EPR_NORMAL, EPR_SELFTEST} epr_mode_e;
	// switch bank: 1 = switch on
	typedef logic [5:0] epr_sw_t;
	// transceiver side of configurable pins one and two
	typedef struct packed {
		logic cts_out;
		logic cts_oe;
		logic dcd_out;
		logic dcd_oe;
	} epr_xcvr_s;
endpackage

// ### epr_pin_router.sv
`timescale 1ns/1ps
`include "epr_regs.svh"
module epr_pin_router import epr_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// mode switch bank, 1 = on
	input wire epr_sw_t mode_switch_bank,
	// configurable pins from the module
	input wire logic config_pin_one,
	input wire logic config_pin_two,
	// config_pin_three is an input of the module
	input wire logic dte_rts,
	input wire logic dte_dtr,
	// transceiver side
	output epr_xcvr_s xcvr,
	output logic config_pin_three_out,
	output logic config_pin_three_oe_n,
	// indicators, 1 = lit
	output logic led_pin_one,
	output logic led_pin_two,
	output logic led_pin_three,
	input wire logic config_pin_three,
	output epr_mode_e mode
);
	// ****************************************
	// switch synchroniser
	// ****************************************
	epr_sw_t sw_meta_q;
	epr_sw_t sw_q;
	logic sel_a, sel_b, sel_c, sel_d;
	// two stages to synchronise the switches; a bouncing switch is not filtered
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sw_meta_q <= `EPR_SW_RST;
			sw_q <= `EPR_SW_RST;
		end else begin
			sw_meta_q <= mode_switch_bank;
			sw_q <= sw_meta_q;
		end
	end
	assign sel_a = sw_q[`EPR_SW_RT_A];
	assign sel_b = sw_q[`EPR_SW_RT_B];
	assign sel_c = sw_q[`EPR_SW_RT_C];
	assign sel_d = sw_q[`EPR_SW_RT_D];

	// ****************************************
	// routing, registered outputs
	// ****************************************
	// clocked by mclk: routes lag switches by three clock cycles
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			xcvr <= '{cts_out: 1'b1, cts_oe: 1'b0, dcd_out: 1'b1, dcd_oe: 1'b0};
			config_pin_three_out <= 1'b1;
			config_pin_three_oe_n <= 1'b1;
		end else begin
			xcvr.cts_oe <= !sel_a;
			xcvr.cts_out <= sel_a ? 1'b1 : config_pin_one;
			xcvr.dcd_oe <= !sel_b;
			xcvr.dcd_out <= sel_b ? 1'b1 : config_pin_two;
			// idle high when isolated so the pin stays free for gpio
			config_pin_three_oe_n <= sel_d;
			if (sel_d)
				config_pin_three_out <= 1'b1;
			else if (sel_c)
				config_pin_three_out <= dte_rts;
			else
				config_pin_three_out <= dte_dtr;
		end
	end

	// ****************************************
	// mode and indicators
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!resetn)
			mode <= EPR_NORMAL;
		else if (sw_q[`EPR_SW_ST_A] && sw_q[`EPR_SW_ST_B])
			mode <= EPR_SELFTEST;
		else
			mode <= EPR_NORMAL;
	end

	logic [2:0] pin_lvl;
	logic [2:0] led_q;
	assign pin_lvl = {config_pin_three, config_pin_two, config_pin_one};
	// one lamp per pin, all three alike
	generate
		for (genvar g = 0; g < 3; g++) begin : g_led
			// a pin pulled low by the module lights its lamp
			always_ff @(posedge mclk) begin
				if (!resetn)
					led_q[g] <= 1'b0;
				else
					led_q[g] <= !pin_lvl[g];
			end
		end
	endgenerate
	assign led_pin_one = led_q[0];
	assign led_pin_two = led_q[1];
	assign led_pin_three = led_q[2];

	// ****************************************
	// checks
	// ****************************************
	a_cts_route: assert property (@(posedge mclk) disable iff (!resetn)
		!sel_a |=> xcvr.cts_oe && xcvr.cts_out == $past(config_pin_one))
		else $error("cts route wrong");
	a_cts_iso: assert property (@(posedge mclk) disable iff (!resetn)
		sel_a |=> !xcvr.cts_oe) else $error("cts not isolated");
	a_dcd_route: assert property (@(posedge mclk) disable iff (!resetn)
		!sel_b |=> xcvr.dcd_oe && xcvr.dcd_out == $past(config_pin_two))
		else $error("dcd route wrong");
	a_dcd_iso: assert property (@(posedge mclk) disable iff (!resetn)
		sel_b |=> !xcvr.dcd_oe) else $error("dcd not isolated");
	a_rts_path: assert property (@(posedge mclk) disable iff (!resetn)
		!sel_d && sel_c |=> !config_pin_three_oe_n
		&& config_pin_three_out == $past(dte_rts))
		else $error("rts path wrong");
	a_dtr_path: assert property (@(posedge mclk) disable iff (!resetn)
		!sel_d && !sel_c |=> config_pin_three_out == $past(dte_dtr))
		else $error("dtr path wrong");
	a_pin3_iso: assert property (@(posedge mclk) disable iff (!resetn)
		sel_d |=> config_pin_three_oe_n) else $error("pin3 driven");
	a_selftest: assert property (@(posedge mclk) disable iff (!resetn)
		##1 (mode == EPR_SELFTEST) == $past(sw_q[`EPR_SW_ST_A]
		&& sw_q[`EPR_SW_ST_B])) else $error("mode wrong");
	a_led_low: assert property (@(posedge mclk) disable iff (!resetn)
		!config_pin_one |=> led_pin_one) else $error("led off");
	a_sync_lag: assert property (@(posedge mclk) disable iff (!resetn)
		$changed(mode_switch_bank) |=> ##1 sw_q == $past(mode_switch_bank, 2))
		else $error("sync lag wrong");

	// ****************************************
	// idle levels of released lines, dtr drive and normal mode
	// ****************************************
	// a released line sits high so the transceiver never sees a false low
	a_cts_idle: assert property (@(posedge mclk) disable iff (!resetn)
		sel_a |=> xcvr.cts_out) else $error("cts idle low");
	a_dcd_idle: assert property (@(posedge mclk) disable iff (!resetn)
		sel_b |=> xcvr.dcd_out) else $error("dcd idle low");
	a_pin3_idle: assert property (@(posedge mclk) disable iff (!resetn)
		sel_d |=> config_pin_three_out) else $error("pin3 idle low");
	a_dtr_drive: assert property (@(posedge mclk) disable iff (!resetn)
		!sel_d && !sel_c |=> !config_pin_three_oe_n)
		else $error("dtr path released");
	a_mode_normal: assert property (@(posedge mclk) disable iff (!resetn)
		!(sw_q[`EPR_SW_ST_A] && sw_q[`EPR_SW_ST_B]) |=> mode == EPR_NORMAL)
		else $error("mode not normal");

	// ****************************************
	// indicator checks
	// ****************************************
	a_led_two: assert property (@(posedge mclk) disable iff (!resetn)
		!config_pin_two |=> led_pin_two) else $error("led two off");
	a_led_three: assert property (@(posedge mclk) disable iff (!resetn)
		!config_pin_three |=> led_pin_three)
		else $error("led three off");
	a_led_dark: assert property (@(posedge mclk) disable iff (!resetn)
		config_pin_one && config_pin_two && config_pin_three
		|=> !led_pin_one && !led_pin_two && !led_pin_three)
		else $error("led lit on high pin");

	// ****************************************
	// switch to route sequences
	// ****************************************
	// two edges to settle a flip, one more to reach the route
	sequence s_route_a_on;
		$rose(mode_switch_bank[`EPR_SW_RT_A]);
	endsequence
	sequence s_cts_let_go;
		##3 !xcvr.cts_oe;
	endsequence
	sequence s_route_a_off;
		$fell(mode_switch_bank[`EPR_SW_RT_A]);
	endsequence
	sequence s_cts_take;
		##3 xcvr.cts_oe;
	endsequence
	sequence s_route_b_on;
		$rose(mode_switch_bank[`EPR_SW_RT_B]);
	endsequence
	sequence s_dcd_let_go;
		##3 !xcvr.dcd_oe;
	endsequence
	sequence s_route_d_on;
		$rose(mode_switch_bank[`EPR_SW_RT_D]);
	endsequence
	sequence s_pin3_let_go;
		##3 config_pin_three_oe_n;
	endsequence
	// a short blip still lands whole, never half a route
	a_cts_release: assert property (@(posedge mclk) disable iff (!resetn)
		s_route_a_on |-> s_cts_let_go)
		else $error("cts release late");
	a_cts_connect: assert property (@(posedge mclk) disable iff (!resetn)
		s_route_a_off |-> s_cts_take)
		else $error("cts connect late");
	a_dcd_release: assert property (@(posedge mclk) disable iff (!resetn)
		s_route_b_on |-> s_dcd_let_go)
		else $error("dcd release late");
	a_pin3_release: assert property (@(posedge mclk) disable iff (!resetn)
		s_route_d_on |-> s_pin3_let_go)
		else $error("pin3 release late");
endmodule // epr_pin_router

// ### epr_dte_model.sv
`timescale 1ns/1ps
// ****
// dte side of the transceiver
// ****
module epr_dte_model import epr_pkg::*; (
	// clock
	input wire logic mclk,
	// levels the bench asks for
	input wire logic rts_req,
	input wire logic dtr_req,
	// dte outputs through the transceiver
	output logic dte_rts,
	output logic dte_dtr
);
	// one register stage, as a real transceiver path is never instant
	always_ff @(posedge mclk) begin
		dte_rts <= rts_req;
		dte_dtr <= dtr_req;
	end
endmodule // epr_dte_model

// ### eval_board_pin_router_test.sv
`timescale 1ns/1ps
module eval_board_pin_router_test import epr_pkg::*; ();
	// ****
	// stimulus and design
	// ****
	logic mclk = 1'b0, resetn = 1'b0, p1 = 1'b1, p2 = 1'b1, p3 = 1'b1;
	logic rts_r = 1'b0, dtr_r = 1'b0, dte_rts, dte_dtr, p3_out, p3_oe_n;
	logic l1, l2, l3;
	epr_sw_t sw = 6'h00;
	epr_xcvr_s xcvr;
	epr_mode_e mode;
	int fails = 0, num_checks = 0;
	// all off, self-test, half, all isolated, mixed, flow control pair
	epr_sw_t corner [6] = '{6'h00, 6'h21, 6'h01, 6'h1E, 6'h14, 6'h08};
	always #10 mclk = ~mclk;
	epr_pin_router u_epr_pin_router (.mclk(mclk), .resetn(resetn),
		.mode_switch_bank(sw), .config_pin_one(p1), .config_pin_two(p2),
		.dte_rts(dte_rts), .dte_dtr(dte_dtr), .xcvr(xcvr),
		.config_pin_three_out(p3_out), .config_pin_three_oe_n(p3_oe_n),
		.led_pin_one(l1), .led_pin_two(l2), .led_pin_three(l3),
		.config_pin_three(p3), .mode(mode));
	epr_dte_model u_epr_dte_model (.mclk(mclk), .rts_req(rts_r),
		.dtr_req(dtr_r), .dte_rts(dte_rts), .dte_dtr(dte_dtr));
	// ****
	// expectations and reporting
	// ****
	// isolated pair idles as out high, enable low
	function automatic logic [1:0] pair_exp(logic iso, logic v);
		return iso ? 2'b10 : {v, 1'b1};
	endfunction
	function automatic logic [1:0] p3_exp(epr_sw_t s, logic r, logic d);
		return s[4] ? 2'b11 : {s[3] ? r : d, 1'b0};
	endfunction
	task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		void'($urandom(60));
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		for (int i = 0; i < 60; i++) begin
			@(posedge mclk);
			sw <= (i < 6) ? corner[i] : epr_sw_t'($urandom);
			{p1, p2, p3, rts_r, dtr_r} <= 5'($urandom);
			// inputs held long enough for the three-stage switch path
			repeat (4) @(posedge mclk);
			#1;
			chk("cts", {2'b00, pair_exp(sw[1], p1)}, {2'b00, xcvr[3:2]});
			chk("dcd", {2'b00, pair_exp(sw[2], p2)}, {2'b00, xcvr[1:0]});
			chk("pin3", {2'b00, p3_exp(sw, rts_r, dtr_r)},
				{2'b00, p3_out, p3_oe_n});
			chk("leds", {1'b0, ~p1, ~p2, ~p3}, {1'b0, l1, l2, l3});
			chk("mode", {3'b000, sw[0] & sw[5]}, {3'b000, mode});
			$display("test %0d done", i);
		end
		// pins one and three as module indicators, both isolated
		@(posedge mclk);
		sw <= 6'h12;
		for (int i = 0; i < 16; i++) begin
			@(posedge mclk);
			p1 <= i[0];
			p3 <= i[2];
			repeat (4) @(posedge mclk);
			#1;
			chk("ind", {~p1, ~p3, 2'b10}, {l1, l3, xcvr[3:2]});
			$display("indicator test %0d done", i);
		end
		wrap_up();
	end
endmodule // eval_board_pin_router_test
